// >>> verilog/frs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_cfg.svh"

module frs_sequencer
  import frs_pkg::*;
#(
  parameter int ROW_WORDS = 32,
  parameter int WORD_W = 24,
  parameter int ERASE_CYC = `FRS_ERASE_US * `FRS_CLK_MHZ,
  parameter int PROG_CYC = `FRS_PROG_US * `FRS_CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [`FRS_ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic tbl_wr,
  input wire logic [WORD_W-1:0] tbl_wdata,
  output logic cpu_stall,
  output logic flash_erase,
  output logic flash_prog,
  output logic [15:0] flash_row_addr,
  output logic [WORD_W-1:0] flash_row_data [ROW_WORDS]
);
  localparam int IW = $clog2(ROW_WORDS);
  localparam int TW = 32;

  // ************************************************
  // registers
  // ************************************************
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [7:0] page_r, page_nxt;
  logic [15:0] offs_r, offs_nxt;
  logic [WORD_W-1:0] buf_r [ROW_WORDS];
  logic [IW-1:0] bidx_r, bidx_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  frs_state_t st_r, st_nxt;
  logic armed;
  logic tdone;
  logic tstart;
  logic [TW-1:0] tload;
  logic trig_ok;
  logic [5:0] op;

  frs_unlock u_unlock (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr),
    .wdata(wdata),
    .armed(armed)
  );

  frs_timer #(.W(TW)) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(tstart),
    .load(tload),
    .done(tdone)
  );

  assign op = ctrl_r[`FRS_OP_MSB:`FRS_OP_LSB];

  // ************************************************
  // trigger qualification
  // ************************************************
  // keys then permit
  assign trig_ok = wr_stb && addr == `FRS_ADR_CTRL && wdata[`FRS_TRIG_BIT]
                   && armed && wdata[`FRS_WPERMIT_BIT] && st_r == FRS_IDLE
                   && ((wdata[`FRS_OP_MSB:`FRS_OP_LSB] == `FRS_OP_ROW_ERASE
                        && wdata[`FRS_ERASE_BIT])
                    || (wdata[`FRS_OP_MSB:`FRS_OP_LSB] == `FRS_OP_ROW_PROG
                        && !wdata[`FRS_ERASE_BIT]));

  // ************************************************
  // control and state
  // ************************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    page_nxt = page_r;
    offs_nxt = offs_r;
    bidx_nxt = bidx_r;
    st_nxt = st_r;
    tstart = 1'b0;
    tload = TW'(PROG_CYC);
    // control is frozen while a cycle runs
    if (wr_stb && addr == `FRS_ADR_CTRL && st_r == FRS_IDLE) begin
      ctrl_nxt = wdata & `FRS_CTRL_WMASK;
    end
    if (wr_stb && addr == `FRS_ADR_PAGE && st_r == FRS_IDLE) begin
      page_nxt = wdata[7:0];
    end
    // dummy table write leaves the row start alone; index steps by one per write
    if (tbl_wr && st_r == FRS_IDLE) begin
      offs_nxt = offs_r;
      bidx_nxt = bidx_r + IW'(1);
    end
    if (wr_stb && addr == `FRS_ADR_OFFS && st_r == FRS_IDLE) begin
      offs_nxt = wdata;
      bidx_nxt = '0;
    end
    case (st_r)
      FRS_IDLE: begin
        if (trig_ok) begin
          ctrl_nxt = (wdata & `FRS_CTRL_WMASK) | (16'h0001 << `FRS_TRIG_BIT);
          tstart = 1'b1;
          if (wdata[`FRS_ERASE_BIT]) begin
            tload = TW'(ERASE_CYC);
            st_nxt = FRS_ERASE;
          end else begin
            st_nxt = FRS_PROG;
          end
        end
      end
      FRS_ERASE, FRS_PROG: begin
        if (tdone) begin
          ctrl_nxt[`FRS_TRIG_BIT] = 1'b0;
          st_nxt = FRS_IDLE;
        end
      end
      default: begin
        st_nxt = FRS_IDLE;
      end
    endcase
  end

  // ************************************************
  // read path
  // ************************************************
  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd_stb) begin
      case (addr)
        `FRS_ADR_CTRL: rdata_nxt = ctrl_r;
        `FRS_ADR_PAGE: rdata_nxt = {8'h00, page_r};
        `FRS_ADR_OFFS: rdata_nxt = offs_r;
        `FRS_ADR_STATUS: rdata_nxt = {13'h0000, armed, st_r != FRS_IDLE,
                                      bidx_r == '0};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r <= `FRS_CTRL_RESET;
      page_r <= 8'h00;
      offs_r <= 16'h0000;
      bidx_r <= '0;
      rdata_r <= 16'h0000;
      st_r <= FRS_IDLE;
    end else begin
      ctrl_r <= ctrl_nxt;
      page_r <= page_nxt;
      offs_r <= offs_nxt;
      bidx_r <= bidx_nxt;
      rdata_r <= rdata_nxt;
      st_r <= st_nxt;
    end
  end

  // ************************************************
  // row write buffers
  // ************************************************
  // one row of buffers
  genvar gi;
  generate
    for (gi = 0; gi < ROW_WORDS; gi++) begin : g_buf
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          buf_r[gi] <= '0;
        end else if (tbl_wr && st_r == FRS_IDLE && bidx_r == IW'(gi)) begin
          buf_r[gi] <= tbl_wdata;
        end
      end
      assign flash_row_data[gi] = buf_r[gi];
    end
  endgenerate

  assign rdata = rdata_r;
  assign cpu_stall = (st_r != FRS_IDLE);
  assign flash_erase = (st_r == FRS_ERASE);
  assign flash_prog = (st_r == FRS_PROG);
  assign flash_row_addr = offs_r & ~16'(ROW_WORDS * 2 - 1);
  logic unused_op;
  assign unused_op = ^op;
endmodule
`default_nettype wire

// >>> verilog/frs_cfg.svh
`ifndef FRS_CFG_SVH
`define FRS_CFG_SVH

// register indices on the plain port
`define FRS_ADDR_W 4
`define FRS_ADR_CTRL 4'h0
`define FRS_ADR_KEY 4'h1
`define FRS_ADR_PAGE 4'h2
`define FRS_ADR_OFFS 4'h3
`define FRS_ADR_BUFDAT 4'h4
`define FRS_ADR_STATUS 4'h5

// control field positions
`define FRS_OP_LSB 0
`define FRS_OP_MSB 5
`define FRS_ERASE_BIT 6
`define FRS_WPERMIT_BIT 14
`define FRS_TRIG_BIT 15
`define FRS_CTRL_RESET 16'h0000
`define FRS_CTRL_WMASK 16'h407F

// operation codes and keys
`define FRS_OP_ROW_ERASE 6'h18
`define FRS_OP_ROW_PROG 6'h04
`define FRS_KEY_FIRST 8'h55
`define FRS_KEY_SECOND 8'hAA

// cycle times in microseconds, clock in MHz
`define FRS_ERASE_US 2000
`define FRS_PROG_US 2000
`define FRS_CLK_MHZ 40

`endif

// >>> verilog/frs_pkg.sv
package frs_pkg;
  typedef enum logic [1:0] {
    FRS_KEY_IDLE = 2'b01,
    FRS_KEY_ARMED = 2'b10
  } frs_key_t;
  typedef enum logic [2:0] {
    FRS_IDLE = 3'b001,
    FRS_ERASE = 3'b010,
    FRS_PROG = 3'b100
  } frs_state_t;
endpackage

// >>> verilog/frs_unlock.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_cfg.svh"
module frs_unlock
  import frs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [`FRS_ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  output logic armed
);
  frs_key_t st_r, st_nxt;
  logic half_r, half_nxt;

  // key pair must be back to back: any other access drops the arming
  always_comb begin
    st_nxt = st_r;
    half_nxt = half_r;
    if (wr_stb || rd_stb) begin
      st_nxt = FRS_KEY_IDLE;
      half_nxt = 1'b0;
      if (wr_stb && addr == `FRS_ADR_KEY) begin
        if (wdata[7:0] == `FRS_KEY_FIRST) begin
          half_nxt = 1'b1;
        end else if (half_r && wdata[7:0] == `FRS_KEY_SECOND) begin
          st_nxt = FRS_KEY_ARMED;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= FRS_KEY_IDLE;
      half_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      half_r <= half_nxt;
    end
  end

  assign armed = (st_r == FRS_KEY_ARMED);
endmodule
`default_nettype wire

// >>> verilog/frs_timer.sv
`timescale 1ns/1ps
`default_nettype none
module frs_timer #(
  parameter int W = 20
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic done
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done = 1'b0;
    if (start) begin
      cnt_nxt = load;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r <= W'(1)) begin
        run_nxt = 1'b0;
        done = 1'b1;
      end else begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/frs_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_cfg.svh"
module frs_seq_monitor #(
  parameter int ERASE_CYC = 8,
  parameter int PROG_CYC = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [`FRS_ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  input wire logic cpu_stall,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic [15:0] flash_row_addr
);
  int cnt_r;
  int cnt_nxt;
  always_comb cnt_nxt = cpu_stall ? cnt_r + 1 : 0;
  always_ff @(posedge clk_sys) cnt_r <= srst ? 0 : cnt_nxt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  key_order_a: assert property (
    $rose(cpu_stall) |-> $past(wr_stb && addr == `FRS_ADR_KEY && wdata[7:0] == `FRS_KEY_SECOND, 2)
      && $past(wr_stb && addr == `FRS_ADR_KEY && wdata[7:0] == `FRS_KEY_FIRST, 3))
    else $error("stall began without the key pair");
  trig_gate_a: assert property (
    $rose(cpu_stall) |-> $past(wr_stb && addr == `FRS_ADR_CTRL && wdata[15] && wdata[14]))
    else $error("stall began without a permitted trigger");
  stall_len_a: assert property (
    $fell(cpu_stall) |-> cnt_r >= ($past(flash_erase) ? ERASE_CYC : PROG_CYC)
      && cnt_r <= ($past(flash_erase) ? ERASE_CYC : PROG_CYC) + 2)
    else $error("cycle length wrong");
  bit_clear_a: assert property (
    rd_stb && addr == `FRS_ADR_CTRL |=> rdata[15] == $past(cpu_stall))
    else $error("trigger bit does not follow the cycle");
  stall_hold_a: assert property (
    flash_erase || flash_prog |-> cpu_stall && !(flash_erase && flash_prog))
    else $error("flash cycle without stall");
  row_align_a: assert property (
    flash_row_addr[5:0] == 6'h00)
    else $error("row address not aligned");
  cover property ($rose(flash_erase));
  cover property ($rose(flash_prog));
  cover property ($fell(cpu_stall));
endmodule
bind frs_sequencer frs_seq_monitor #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) i_mon (
  .clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
  .flash_prog(flash_prog), .flash_row_addr(flash_row_addr));
`default_nettype wire

// >>> testbench/frs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module frs_core_model #(
  parameter int WORD_W = 24,
  parameter logic [23:0] PAT = 24'h5A0000
) (
  input wire logic clk_sys,
  input wire logic go,
  output logic tbl_wr,
  output logic [WORD_W-1:0] tbl_wdata
);
  int k = 32;
  initial tbl_wr = 1'b0;
  initial tbl_wdata = '0;
  // whole row of 32 words, back to back
  always @(posedge clk_sys) begin
    if (k < 32) begin
      tbl_wr <= 1'b1;
      tbl_wdata <= WORD_W'(PAT + k);
      k <= k + 1;
    end else begin
      tbl_wr <= 1'b0;
      // idle data toggles so a stale word is never mistaken for a fresh one
      tbl_wdata <= ~tbl_wdata;
      if (go) k <= 0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_cfg.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [`FRS_ADDR_W-1:0] addr = '0;
  logic [15:0] wdata = '0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic go = 1'b0;
  logic tbl_wr, cpu_stall, flash_erase, flash_prog;
  logic [23:0] tbl_wdata;
  logic [15:0] rdata, flash_row_addr;
  logic [23:0] flash_row_data [32];
  logic [15:0] ops [2] = '{16'h4058, 16'h4004};
  int mismatches = 0;
  int checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  frs_sequencer #(.ERASE_CYC(8), .PROG_CYC(8)) i_dut (
    .clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .tbl_wr(tbl_wr), .tbl_wdata(tbl_wdata),
    .cpu_stall(cpu_stall), .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_row_addr(flash_row_addr), .flash_row_data(flash_row_data));
  frs_core_model i_core (.clk_sys(clk_sys), .go(go), .tbl_wr(tbl_wr), .tbl_wdata(tbl_wdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr_stb <= w;
    rd_stb <= r;
    addr <= a;
    wdata <= d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    acc(1'b0, 1'b1, a, 16'h0000);
    acc(1'b0, 1'b0, a, 16'h0000);
    #1 chk(32'(rdata), 32'(exp));
  endtask
  task automatic test_done();
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`FRS_ADR_CTRL, 16'h0000);
    rd(`FRS_ADR_STATUS, 16'h0001);
    rd(4'hF, 16'h0000);
    // page pointer keeps its low byte only, row start through the offset register
    acc(1'b1, 1'b0, `FRS_ADR_PAGE, 16'hAB12);
    rd(`FRS_ADR_PAGE, 16'h0012);
    acc(1'b1, 1'b0, `FRS_ADR_OFFS, 16'h0040);
    acc(1'b0, 1'b0, 4'h0, 16'h0000);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk(32'(flash_row_addr), 32'h0040);
    for (int i = 0; i < 32; i++) chk(32'(flash_row_data[i]), 32'(24'h5A0000 + i));
    foreach (ops[o]) begin
      for (int j = 0; j < 3; j++) begin
        // no keys, a status read between keys and trigger, or a trigger without the permit bit
        if (j > 0) acc(1'b1, 1'b0, `FRS_ADR_KEY, 16'h0055);
        if (j > 0) acc(1'b1, 1'b0, `FRS_ADR_KEY, 16'h00AA);
        if (j == 1) acc(1'b0, 1'b1, `FRS_ADR_STATUS, 16'h0000);
        acc(1'b1, 1'b0, `FRS_ADR_CTRL, (j == 2 ? ops[o] & 16'h3FFF : ops[o]) | 16'h8000);
        if (j == 1) #1 chk(32'(rdata), 32'h0005);
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        #1 chk(32'(cpu_stall), 32'(j == 3));
      end
      acc(1'b1, 1'b0, `FRS_ADR_KEY, 16'h0055);
      acc(1'b1, 1'b0, `FRS_ADR_KEY, 16'h00AA);
      acc(1'b1, 1'b0, `FRS_ADR_CTRL, ops[o] | 16'h8000);
      // two idle slots follow the trigger write
      acc(1'b0, 1'b0, 4'h0, 16'h0000);
      acc(1'b0, 1'b0, 4'h0, 16'h0000);
      #1 chk(32'({cpu_stall, flash_erase, flash_prog}), 32'({1'b1, ops[o][6], !ops[o][6]}));
      rd(`FRS_ADR_CTRL, ops[o] | 16'h8000);
      rd(`FRS_ADR_STATUS, 16'h0003);
      for (int n = 0; n < 20 && cpu_stall; n++) begin
        @(posedge clk_sys);
        #1;
      end
      chk(32'(cpu_stall), 32'h0);
      rd(`FRS_ADR_CTRL, ops[o]);
    end
    test_done();
  end
endmodule
`default_nettype wire
